// file: rtl/psr_pkg.sv
// Constants shared by the peripheral software reset block: register
// indices, field positions, reset values and the address decode helper.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package psr_pkg;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [15:0] PULSE_LEN_IDX = 16'h1c04;
    localparam logic [15:0] TRIG_IDX = 16'h1c05;

    // Bit positions of the reset control register.
    localparam int GRP4_BIT = 7;
    localparam int GRP3_BIT = 5;
    localparam int DMA_BIT = 4;
    localparam int USB_BIT = 3;
    localparam int ANALOG_BIT = 2;
    localparam int GRP1_BIT = 1;
    localparam int I2C_BIT = 0;

    // Writable trigger bits; bit 6 and the upper byte are reserved.
    localparam logic [7:0] TRIG_WRITE_MASK = 8'hbf;

    // Values after reset.
    localparam logic [15:0] PULSE_LEN_RESET = 16'h0008;
    localparam logic [7:0] TRIG_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // Smallest pulse length that software is advised to program.
    localparam logic [15:0] PULSE_LEN_MIN = 16'h0008;

    typedef enum logic [1:0] {
        PSR_IDLE = 2'b01,
        PSR_HOLD = 2'b10
    } psr_state_t;

    // True when a byte address selects the register of the given index.
    function automatic logic psr_hit(input logic [31:0] adr, input logic [15:0] idx);
        psr_hit = (adr[31:18] == 14'h0000) && (adr[17:2] == idx);
    endfunction : psr_hit

endpackage : psr_pkg

// file: rtl/psr_reg_if.sv
// Carrier between the bus slave, the pulse timer and the core of the
// peripheral software reset block. Assumes all three share mclk.
interface psr_reg_if;
    logic wrLen;
    logic wrTrig;
    logic [15:0] wrData;
    logic [1:0] wrByteEn;
    logic [15:0] lenVal;
    logic [7:0] trigVal;
    logic tmrLoad;
    logic [15:0] tmrLoadVal;
    logic tmrRun;
    logic tmrExpire;

    modport slave (
        output wrLen,
        output wrTrig,
        output wrData,
        output wrByteEn,
        input lenVal,
        input trigVal
    );

    modport timer (
        input tmrLoad,
        input tmrLoadVal,
        input tmrRun,
        output tmrExpire
    );

    modport core (
        input wrLen,
        input wrTrig,
        input wrData,
        input wrByteEn,
        output lenVal,
        output trigVal,
        output tmrLoad,
        output tmrLoadVal,
        output tmrRun,
        input tmrExpire
    );
endinterface : psr_reg_if

// file: rtl/psr_wb_slave.sv
// Classic Wishbone slave for the peripheral software reset registers.
// Assumes a single-cycle master that holds its request until ack.
module psr_wb_slave (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [31:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatIn,
    output logic [31:0] wbDatOut,
    output logic wbAck,
    psr_reg_if.slave regs
);
    logic ack_ff;
    logic nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic hitLen;
    logic hitTrig;

    // Ack comes one cycle after the request and lasts one cycle; unmapped
    // addresses are acknowledged too and read as zero, so no bus hangs.
    always_comb begin
        hitLen = psr_pkg::psr_hit(wbAdr, psr_pkg::PULSE_LEN_IDX);
        hitTrig = psr_pkg::psr_hit(wbAdr, psr_pkg::TRIG_IDX);
        nxt_ack = wbCyc && wbStb && !ack_ff;
        nxt_rdata = psr_pkg::RDATA_RESET;
        if (nxt_ack && !wbWe && hitLen) begin
            nxt_rdata = {16'h0000, regs.lenVal};
        end else if (nxt_ack && !wbWe && hitTrig) begin
            // (R05) Status read back.
            nxt_rdata = {24'h00_0000, regs.trigVal};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_ff <= 1'b0;
            rdata_ff <= psr_pkg::RDATA_RESET;
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    // Writes land at the edge on which the master sees ack.
    assign regs.wrLen = wbCyc && wbStb && wbWe && ack_ff && hitLen;
    assign regs.wrTrig = wbCyc && wbStb && wbWe && ack_ff && hitTrig;
    assign regs.wrData = wbDatIn[15:0];
    assign regs.wrByteEn = wbSel[1:0];
    assign wbAck = ack_ff;
    assign wbDatOut = rdata_ff;
endmodule : psr_wb_slave

// file: rtl/psr_pulse_timer.sv
// Down counter that times one software reset pulse.
// Assumes load and run come from logic on mclk.
module psr_pulse_timer #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic srst,
    psr_reg_if.timer tmr
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // (R01) Load length minus one.
    // A length of zero is treated as one cycle, the shortest pulse possible.
    always_comb begin
        nxt_cnt = cnt_ff;
        if (tmr.tmrLoad) begin
            nxt_cnt = (tmr.tmrLoadVal == '0) ? '0 : CNT_W'(tmr.tmrLoadVal - 1'b1);
        end else if (tmr.tmrRun && cnt_ff != '0) begin
            nxt_cnt = CNT_W'(cnt_ff - 1'b1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_ff <= CNT_W'(psr_pkg::COUNT_RESET);
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // (R03) Expiry at zero.
    assign tmr.tmrExpire = tmr.tmrRun && (cnt_ff == '0) && !tmr.tmrLoad;
endmodule : psr_pulse_timer

// file: rtl/psr_top.sv
// Peripheral software reset generator: a pulse length register, a trigger
// register and active-low reset lines to the peripheral groups.
// Assumes one clock, mclk, and a classic Wishbone master on the bus side.
// Software is expected to poll the trigger bits before using a peripheral.

// Operation
// (R01) Each triggered line stays asserted exactly the programmed count of clock cycles; a reload holds earlier lines until the new count ends.
// (R01) The code holds the lines for one cycle when the programmed count is zero.
// (R02) Peripheral reset lines are driven low while the count runs.
// (R03) When the counter reaches zero, all set trigger bits clear automatically.
// (R04) Writing a one to a trigger bit starts that group's reset.
// (R05) Reading the trigger register returns the live state of each group's reset.
// (R06) Software must not touch a peripheral until the count has elapsed.
// (R07) Software programs a pulse length of at least eight before triggering.
// (R08) Software writes length eight first, then sets the wanted trigger bits.
// (R09) One trigger bit may reset several peripherals; group 4 resets five.
// (R10) Bits: group4=7, group3=5, DMA=4, USB=3, analog=2, group1=1, I2C=0.
// (R11) Writing zero to a trigger bit neither starts nor shortens a reset.
// (R12) Software writes zeros to reserved bit 6 and the upper byte.
// (R13) A write during a count adds groups and reloads the counter.
module psr_top (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic lcdRstN,
    output logic i2s2RstN,
    output logic i2s3RstN,
    output logic uartRstN,
    output logic spiRstN,
    output logic mmcSd0RstN,
    output logic mmcSd1RstN,
    output logic i2s0RstN,
    output logic i2s1RstN,
    output logic [3:0] dmaCtrlRstN,
    output logic usbRstN,
    output logic analogConvRstN,
    output logic emifRstN,
    output logic [2:0] timerRstN,
    output logic i2cRstN,
    output logic pulseBusy
);
    // Register writes, timer control and status travel on one carrier, so
    // the slave and the timer see a single, consistent view of the core.
    psr_reg_if regBus ();

    logic [15:0] pulseLen_ff;
    logic [15:0] nxt_pulseLen;
    logic [7:0] active_ff;
    logic [7:0] nxt_active;
    logic [7:0] setBits;
    psr_pkg::psr_state_t state_ff;
    psr_pkg::psr_state_t nxt_state;

    // One flop per line rather than one per group: each pin then has its own
    // driver and can be placed near the peripheral that it resets.
    logic lcdRstN_ff;
    logic i2s2RstN_ff;
    logic i2s3RstN_ff;
    logic uartRstN_ff;
    logic spiRstN_ff;
    logic mmcSd0RstN_ff;
    logic mmcSd1RstN_ff;
    logic i2s0RstN_ff;
    logic i2s1RstN_ff;
    logic [3:0] dmaCtrlRstN_ff;
    logic usbRstN_ff;
    logic analogConvRstN_ff;
    logic emifRstN_ff;
    logic [2:0] timerRstN_ff;
    logic i2cRstN_ff;
    logic pulseBusy_ff;

    // Next values of the line flops.
    logic nxt_lcdRstN;
    logic nxt_i2s2RstN;
    logic nxt_i2s3RstN;
    logic nxt_uartRstN;
    logic nxt_spiRstN;
    logic nxt_mmcSd0RstN;
    logic nxt_mmcSd1RstN;
    logic nxt_i2s0RstN;
    logic nxt_i2s1RstN;
    logic [3:0] nxt_dmaCtrlRstN;
    logic nxt_usbRstN;
    logic nxt_analogConvRstN;
    logic nxt_emifRstN;
    logic [2:0] nxt_timerRstN;
    logic nxt_i2cRstN;
    logic nxt_pulseBusy;

    // Turns a held group bit into the active-low level of its lines.
    // Kept as a function so every group decodes its bit the same way.
    function automatic logic psr_line_n(input logic [7:0] grp, input int pos);
        psr_line_n = !grp[pos];
    endfunction : psr_line_n

    // Merges the byte lanes of a 16-bit register write.
    function automatic logic [15:0] psr_merge(
        input logic [15:0] old,
        input logic [15:0] wdata,
        input logic [1:0] ben
    );
        psr_merge = old;
        if (ben[0]) begin
            psr_merge[7:0] = wdata[7:0];
        end
        if (ben[1]) begin
            psr_merge[15:8] = wdata[15:8];
        end
    endfunction : psr_merge

    // The slave acknowledges every access one cycle after taking it, and
    // acknowledges unmapped addresses as well, so software never stalls.
    psr_wb_slave psr_wb_slave_inst (
        .mclk(mclk),
        .srst(srst),
        .wbCyc(wb_cyc_i),
        .wbStb(wb_stb_i),
        .wbWe(wb_we_i),
        .wbAdr(wb_adr_i),
        .wbSel(wb_sel_i),
        .wbDatIn(wb_dat_i),
        .wbDatOut(wb_dat_o),
        .wbAck(wb_ack_o),
        .regs(regBus.slave)
    );

    // The counter is as wide as the length field, so every programmable
    // length is reachable without a prescaler.
    psr_pulse_timer #(
        .CNT_W(16)
    ) psr_pulse_timer_inst (
        .mclk(mclk),
        .srst(srst),
        .tmr(regBus.timer)
    );

    // The length is only sampled when a trigger write sets bits, so rewriting it
    // mid-pulse never stretches or cuts the pulse already running.
    always_comb begin
        nxt_pulseLen = pulseLen_ff;
        if (regBus.wrLen) begin
            nxt_pulseLen = psr_merge(pulseLen_ff, regBus.wrData, regBus.wrByteEn);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pulseLen_ff <= psr_pkg::PULSE_LEN_RESET;
        end else begin
            pulseLen_ff <= nxt_pulseLen;
        end
    end

    // Trigger register and sequence state.
    always_comb begin
        setBits = 8'h00;
        // (R04) Ones start resets.
        // (R11) Zeros are ignored.
        // (R12) Reserved bits masked.
        if (regBus.wrTrig && regBus.wrByteEn[0]) begin
            setBits = regBus.wrData[7:0] & psr_pkg::TRIG_WRITE_MASK;
        end
        // (R03) Clear on expiry.
        // (R13) New ones join the set.
        // A set in the expiry cycle survives, so no trigger is lost.
        nxt_active = (regBus.tmrExpire ? 8'h00 : active_ff) | setBits;
        // A reload in the expiry cycle holds the earlier groups for the new
        // count as well, because the timer suppresses expiry while loading.
        nxt_state = state_ff;
        case (state_ff)
            psr_pkg::PSR_IDLE: begin
                // A pulse starts only from a write of ones.
                if (setBits != 8'h00) begin
                    nxt_state = psr_pkg::PSR_HOLD;
                end
            end
            psr_pkg::PSR_HOLD: begin
                // Stay until no group is held any more.
                if (nxt_active == 8'h00) begin
                    nxt_state = psr_pkg::PSR_IDLE;
                end
            end
            default: begin
                nxt_state = psr_pkg::PSR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            // The block's own reset drops every held group at once.
            active_ff <= psr_pkg::TRIG_RESET;
            state_ff <= psr_pkg::PSR_IDLE;
        end else begin
            active_ff <= nxt_active;
            state_ff <= nxt_state;
        end
    end

    // (R01) Length taken at trigger.
    // (R13) Reload on any set.
    assign regBus.tmrLoad = (setBits != 8'h00);
    assign regBus.tmrLoadVal = pulseLen_ff;
    assign regBus.tmrRun = (state_ff == psr_pkg::PSR_HOLD);
    assign regBus.lenVal = pulseLen_ff;
    // (R05) Live reset state.
    assign regBus.trigVal = active_ff;

    // Reset lines follow the next trigger state so they coincide with it.
    always_comb begin
        // (R02) Active-low lines.
        // (R09) Group 4 fanout.
        nxt_lcdRstN = psr_line_n(nxt_active, psr_pkg::GRP4_BIT);
        nxt_i2s2RstN = psr_line_n(nxt_active, psr_pkg::GRP4_BIT);
        nxt_i2s3RstN = psr_line_n(nxt_active, psr_pkg::GRP4_BIT);
        nxt_uartRstN = psr_line_n(nxt_active, psr_pkg::GRP4_BIT);
        nxt_spiRstN = psr_line_n(nxt_active, psr_pkg::GRP4_BIT);
        // (R09) Group 3 fanout.
        nxt_mmcSd0RstN = psr_line_n(nxt_active, psr_pkg::GRP3_BIT);
        nxt_mmcSd1RstN = psr_line_n(nxt_active, psr_pkg::GRP3_BIT);
        nxt_i2s0RstN = psr_line_n(nxt_active, psr_pkg::GRP3_BIT);
        nxt_i2s1RstN = psr_line_n(nxt_active, psr_pkg::GRP3_BIT);
        // (R09) All DMA controllers.
        nxt_dmaCtrlRstN = {4{psr_line_n(nxt_active, psr_pkg::DMA_BIT)}};
        // (R10) Single-line groups.
        nxt_usbRstN = psr_line_n(nxt_active, psr_pkg::USB_BIT);
        nxt_analogConvRstN = psr_line_n(nxt_active, psr_pkg::ANALOG_BIT);
        // (R09) Group 1 fanout, then the single I2C line.
        nxt_emifRstN = psr_line_n(nxt_active, psr_pkg::GRP1_BIT);
        nxt_timerRstN = {3{psr_line_n(nxt_active, psr_pkg::GRP1_BIT)}};
        nxt_i2cRstN = psr_line_n(nxt_active, psr_pkg::I2C_BIT);
        // Busy mirrors the trigger register, so either may be polled.
        nxt_pulseBusy = (nxt_active != 8'h00);
    end

    // Lines are released during the block's own reset; a peripheral is
    // only held by software request, never by this block's power-up.
    always_ff @(posedge mclk) begin
        if (srst) begin
            lcdRstN_ff <= 1'b1;
            i2s2RstN_ff <= 1'b1;
            i2s3RstN_ff <= 1'b1;
            uartRstN_ff <= 1'b1;
            spiRstN_ff <= 1'b1;
            mmcSd0RstN_ff <= 1'b1;
            mmcSd1RstN_ff <= 1'b1;
            i2s0RstN_ff <= 1'b1;
            i2s1RstN_ff <= 1'b1;
            dmaCtrlRstN_ff <= 4'hf;
            usbRstN_ff <= 1'b1;
            analogConvRstN_ff <= 1'b1;
            emifRstN_ff <= 1'b1;
            timerRstN_ff <= 3'h7;
            i2cRstN_ff <= 1'b1;
            pulseBusy_ff <= 1'b0;
        end else begin
            lcdRstN_ff <= nxt_lcdRstN;
            i2s2RstN_ff <= nxt_i2s2RstN;
            i2s3RstN_ff <= nxt_i2s3RstN;
            uartRstN_ff <= nxt_uartRstN;
            spiRstN_ff <= nxt_spiRstN;
            mmcSd0RstN_ff <= nxt_mmcSd0RstN;
            mmcSd1RstN_ff <= nxt_mmcSd1RstN;
            i2s0RstN_ff <= nxt_i2s0RstN;
            i2s1RstN_ff <= nxt_i2s1RstN;
            dmaCtrlRstN_ff <= nxt_dmaCtrlRstN;
            usbRstN_ff <= nxt_usbRstN;
            analogConvRstN_ff <= nxt_analogConvRstN;
            emifRstN_ff <= nxt_emifRstN;
            timerRstN_ff <= nxt_timerRstN;
            i2cRstN_ff <= nxt_i2cRstN;
            pulseBusy_ff <= nxt_pulseBusy;
        end
    end

    // Pins come straight from flops, so no decode glitch reaches a peripheral.
    assign lcdRstN = lcdRstN_ff;
    assign i2s2RstN = i2s2RstN_ff;
    assign i2s3RstN = i2s3RstN_ff;
    assign uartRstN = uartRstN_ff;
    assign spiRstN = spiRstN_ff;

    assign mmcSd0RstN = mmcSd0RstN_ff;
    assign mmcSd1RstN = mmcSd1RstN_ff;
    assign i2s0RstN = i2s0RstN_ff;
    assign i2s1RstN = i2s1RstN_ff;

    assign dmaCtrlRstN = dmaCtrlRstN_ff;

    assign usbRstN = usbRstN_ff;
    assign analogConvRstN = analogConvRstN_ff;

    assign emifRstN = emifRstN_ff;
    assign timerRstN = timerRstN_ff;

    assign i2cRstN = i2cRstN_ff;
    assign pulseBusy = pulseBusy_ff;
endmodule : psr_top

// file: bench/psr_asserts.sv
// Concurrent checks on the ports of psr_top.
// Assumes it is bound to psr_top and sees only its ports.
module psr_asserts (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic lcdRstN,
    input wire logic i2s2RstN,
    input wire logic i2s3RstN,
    input wire logic uartRstN,
    input wire logic spiRstN,
    input wire logic mmcSd0RstN,
    input wire logic mmcSd1RstN,
    input wire logic i2s0RstN,
    input wire logic i2s1RstN,
    input wire logic [3:0] dmaCtrlRstN,
    input wire logic usbRstN,
    input wire logic analogConvRstN,
    input wire logic emifRstN,
    input wire logic [2:0] timerRstN,
    input wire logic i2cRstN,
    input wire logic pulseBusy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] lines;
    logic [7:0] stateBits;
    logic wrAck;
    logic trigOnes;
    logic [15:0] lenShadow_ff;
    logic [15:0] nxt_lenShadow;
    logic [16:0] holdCnt_ff;
    logic [16:0] nxt_holdCnt;
    logic [16:0] lenAt_ff;
    logic [16:0] nxt_lenAt;
    assign lines = {lcdRstN, i2s2RstN, i2s3RstN, uartRstN, spiRstN, mmcSd0RstN, mmcSd1RstN,
        i2s0RstN, i2s1RstN, dmaCtrlRstN, usbRstN, analogConvRstN, emifRstN, timerRstN, i2cRstN};
    assign stateBits = {~lcdRstN, 1'b0, ~mmcSd0RstN, ~dmaCtrlRstN[0], ~usbRstN,
        ~analogConvRstN, ~emifRstN, ~i2cRstN};
    assign wrAck = wb_ack_o && wb_we_i;
    assign trigOnes = wrAck && wb_adr_i == 32'h0000_7014 && wb_sel_i[0]
        && (wb_dat_i[7:0] & 8'hbf) != 8'h00;
    // The shadow length follows length writes; lenAt latches it at each trigger, so a later length write cannot skew it.
    always_comb begin
        nxt_lenShadow = lenShadow_ff;
        nxt_holdCnt = pulseBusy ? holdCnt_ff + 17'h1 : holdCnt_ff;
        nxt_lenAt = lenAt_ff;
        if (wrAck && wb_adr_i == 32'h0000_7010) begin
            if (wb_sel_i[0]) nxt_lenShadow[7:0] = wb_dat_i[7:0];
            if (wb_sel_i[1]) nxt_lenShadow[15:8] = wb_dat_i[15:8];
        end
        if (trigOnes) begin
            nxt_holdCnt = 17'h1;
            nxt_lenAt = (lenShadow_ff == 16'h0) ? 17'h1 : {1'b0, lenShadow_ff};
        end
    end
    always_ff @(posedge mclk) begin
        if (srst) begin
            lenShadow_ff <= psr_pkg::PULSE_LEN_RESET;
            holdCnt_ff <= 17'h0;
            lenAt_ff <= 17'h0;
        end else begin
            lenShadow_ff <= nxt_lenShadow;
            holdCnt_ff <= nxt_holdCnt;
            lenAt_ff <= nxt_lenAt;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    AST_TRIG_LOW: assert property (trigOnes && wb_dat_i[7] |=> !lcdRstN && !spiRstN)
        else $error("group 4 did not enter reset after trigger");
    AST_ZERO_KEEP: assert property (wrAck && wb_adr_i == 32'h0000_7014 && !wb_dat_i[3]
        && usbRstN |=> usbRstN)
        else $error("zero write started a reset");
    AST_GRP4_TIE: assert property (lines[19:15] inside {5'h00, 5'h1f})
        else $error("group 4 lines split");
    AST_GRP_TIE: assert property (lines[14:11] inside {4'h0, 4'hf}
        && lines[10:7] inside {4'h0, 4'hf} && lines[4:1] inside {4'h0, 4'hf})
        else $error("group lines split");
    AST_BUSY: assert property (pulseBusy == (lines != 20'hf_ffff))
        else $error("busy disagrees with reset lines");
    AST_HOLD_LEN: assert property ($fell(pulseBusy) |-> holdCnt_ff == lenAt_ff + 17'h1)
        else $error("reset pulse length wrong");
    AST_CLEAR_ALL: assert property ($rose(usbRstN) || $rose(lcdRstN) || $rose(i2cRstN)
        |-> lines == 20'hf_ffff && !pulseBusy)
        else $error("reset lines not released together");
    AST_READ_TRIG: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 32'h0000_7014
        |-> wb_dat_o == {24'h00_0000, $past(stateBits)})
        else $error("trigger readback differs from lines");
endmodule : psr_asserts

bind psr_top psr_asserts psr_asserts_inst (.mclk, .srst, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .lcdRstN, .i2s2RstN, .i2s3RstN, .uartRstN, .spiRstN,
    .mmcSd0RstN, .mmcSd1RstN, .i2s0RstN, .i2s1RstN, .dmaCtrlRstN, .usbRstN, .analogConvRstN,
    .emifRstN, .timerRstN, .i2cRstN, .pulseBusy);

// file: bench/psr_periph_model.sv
// Stand-in for the peripherals behind the reset lines: times each pulse.
// Assumes registered lines on mclk that idle high.
module psr_periph_model #(
    parameter int W = 20
) (
    input wire logic mclk,
    input wire logic [W-1:0] rstN,
    output logic [15:0] lowLen,
    output logic [W-1:0] lowMask
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt = 16'h0;
    logic [W-1:0] seen = '0;
    logic [15:0] lenSeen = 16'h0;
    logic [W-1:0] maskSeen = '0;
    assign lowLen = lenSeen;
    assign lowMask = maskSeen;
    always @(posedge mclk) begin
        if (!(&rstN)) begin
            cnt <= cnt + 16'h1;
            seen <= seen | ~rstN;
        end else if (cnt != 16'h0) begin
            lenSeen <= cnt;
            maskSeen <= seen;
            cnt <= 16'h0;
            seen <= '0;
        end
    end
endmodule : psr_periph_model

// file: bench/tb_peripheral_software_reset.sv
// Self-checking bench for psr_top over classic Wishbone.
// Assumes the checker is bound and the peripheral model times each pulse.
module tb_peripheral_software_reset;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] LEN_A = 32'h0000_7010;
    localparam logic [31:0] TRIG_A = 32'h0000_7014;
    logic mclk, srst, cyc, stb, we, ack, busy;
    logic [31:0] adr, wdat, rd, rdat;
    logic [3:0] sel;
    wire logic [19:0] lines;
    logic [19:0] lowMask;
    logic [15:0] lowLen;
    int n_mismatch, cmp_count, eAck, e1, e2;
    int cycN = 0;
    int bits [7] = '{7, 5, 4, 3, 2, 1, 0};
    logic [19:0] masks [7] = '{20'hf_8000, 20'h0_7800, 20'h0_0780, 20'h0_0040,
        20'h0_0020, 20'h0_001e, 20'h0_0001};
    psr_top psr_top_inst (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd),
        .wb_ack_o(ack), .lcdRstN(lines[19]), .i2s2RstN(lines[18]), .i2s3RstN(lines[17]),
        .uartRstN(lines[16]), .spiRstN(lines[15]), .mmcSd0RstN(lines[14]),
        .mmcSd1RstN(lines[13]), .i2s0RstN(lines[12]), .i2s1RstN(lines[11]),
        .dmaCtrlRstN(lines[10:7]), .usbRstN(lines[6]), .analogConvRstN(lines[5]),
        .emifRstN(lines[4]), .timerRstN(lines[3:1]), .i2cRstN(lines[0]), .pulseBusy(busy));
    psr_periph_model psr_periph_model_inst (.mclk(mclk), .rstN(lines), .lowLen(lowLen),
        .lowMask(lowMask));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) cycN <= cycN + 1;
    task test_done;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task chk(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk
    // Holds the request until ack is sampled high, then releases it.
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        k = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            test_done();
        end
        rdat = rd;
        eAck = cycN;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : xfer
    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000, 4'hf);
        chk(exp, rdat);
    endtask : rdchk
    // Software polls the trigger register before touching a peripheral.
    task wait_clear;
        int k;
        k = 0;
        do begin
            xfer(1'b0, TRIG_A, 32'h0000_0000, 4'hf);
            k++;
        end while (rdat !== 32'h0000_0000 && k < 500);
        if (k >= 500) begin
            n_mismatch++;
            test_done();
        end
        repeat (2) @(posedge mclk);
    endtask : wait_clear
    initial begin
        srst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 32'h0000_0000;
        wdat = 32'h0000_0000;
        sel = 4'h0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        rdchk(LEN_A, 32'h0000_0008);
        rdchk(TRIG_A, 32'h0000_0000);
        chk(32'h000f_ffff, {12'h000, lines});
        xfer(1'b1, 32'h0000_7018, 32'h0000_ffff, 4'hf);
        rdchk(32'h0000_7018, 32'h0000_0000);
        rdchk(LEN_A, 32'h0000_0008);
        xfer(1'b1, LEN_A, 32'h0000_0008, 4'h3);
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, TRIG_A, 32'h0000_0001 << bits[i], 4'h1);
            rdchk(TRIG_A, 32'h0000_0001 << bits[i]);
            chk({12'h000, ~masks[i]}, {12'h000, lines});
            chk(32'h0000_0001, {31'h0, busy});
            wait_clear();
            chk({12'h000, masks[i]}, {12'h000, lowMask});
            chk(32'h0000_0008, {16'h0000, lowLen});
        end
        xfer(1'b1, TRIG_A, 32'h0000_ff40, 4'hf);
        rdchk(TRIG_A, 32'h0000_0000);
        chk(32'h0000_0000, {31'h0, busy});
        xfer(1'b1, LEN_A, 32'h0000_ab0c, 4'h1);
        rdchk(LEN_A, 32'h0000_000c);
        xfer(1'b1, TRIG_A, 32'h0000_0008, 4'h1);
        e1 = eAck;
        xfer(1'b1, TRIG_A, 32'h0000_0000, 4'h1);
        xfer(1'b1, TRIG_A, 32'h0000_0001, 4'h1);
        e2 = eAck;
        wait_clear();
        chk(32'h0000_0041, {12'h000, lowMask});
        chk(32'(e2 - e1 + 12), {16'h0000, lowLen});
        chk(32'h0000_0000, {31'h0, busy});
        test_done();
    end
endmodule : tb_peripheral_software_reset
